// *** verilog/seep_defs.svh ***
// Constants for the serial EEPROM command engine: opcodes, status layout, timing.
// Assumes inclusion by the engine; no processes here.
// ==========================================================================
`ifndef SEEP_DEFS_SVH
`define SEEP_DEFS_SVH

// Low three opcode bits; upper four must be zero, bit 3 ignored
`define SEEP_OP_SET_WRITE_LATCH 3'h6
`define SEEP_OP_CLR_WRITE_LATCH 3'h4
`define SEEP_OP_READ_STATUS     3'h5
`define SEEP_OP_READ_ARRAY      3'h3
`define SEEP_OP_WRITE_ARRAY     3'h2

// Status byte field positions
`define SEEP_ST_BUSY_BIT   0
`define SEEP_ST_LATCH_BIT  1
`define SEEP_ST_LVL_LO_BIT 2
`define SEEP_ST_LVL_HI_BIT 3
`define SEEP_ST_GATE_BIT   7

// Reset value of the level and gate bits
`define SEEP_LEVEL_RESET 2'h0
`define SEEP_GATE_RESET  1'h0

// Self-timed cycle length
`define SEEP_TWC_US    5000
`define SEEP_CLK_MHZ   25
`define SEEP_TWC_CYCLES (`SEEP_TWC_US * `SEEP_CLK_MHZ)

`endif

// *** verilog/seep_pkg.sv ***
// Types shared by the serial EEPROM engine and its memory.
// Assumes the defs header sits on the include path.
package seep_pkg;
    // ======================================================================
    // Frame phases, one-hot
    typedef enum logic [5:0] {
        SEEP_OPC  = 6'b00_0001,  // Collecting opcode
        SEEP_ADR  = 6'b00_0010,  // Collecting 16-bit address
        SEEP_RDAT = 6'b00_0100,  // Shifting array data out
        SEEP_WDAT = 6'b00_1000,  // Collecting write data
        SEEP_STAT = 6'b01_0000,  // Shifting status out
        SEEP_IGN  = 6'b10_0000   // Ignoring rest of frame
    } seep_phase_t;

    // Memory write request
    typedef struct packed {
        logic        we;
        logic [14:0] addr;
        logic [7:0]  data;
    } seep_wr_t;
endpackage : seep_pkg

// *** verilog/seep_mem.sv ***
// Byte array with registered read data.
// Assumes single clock; write and read in one cycle allowed.
`timescale 1ns/1ps
module seep_mem
    import seep_pkg::*;
#(
    parameter int AW = 15
) (
    input  wire logic          clk,
    input  wire seep_wr_t      wr,
    input  wire logic [AW-1:0] raddr,
    output logic [7:0]         rdata
);
    // ======================================================================
    // Storage
    logic [7:0] mem [0:(1<<AW)-1];  // Array cells

    initial begin
        if (AW < 6 || AW > 15) $error("seep_mem: AW out of range");
    end

    // Write port and registered read; no reset, cells hold contents
    always_ff @(posedge clk) begin
        if (wr.we) begin
            mem[wr.addr[AW-1:0]] <= wr.data;
        end
        rdata <= mem[raddr];
    end
endmodule : seep_mem

// *** verilog/seep_engine.sv ***
// Serial EEPROM command engine: opcode decode, read stream, page write, protect.
// Assumes SCK, CS_N and SI are synchronous to CLK and oversampled (SCK < CLK/4).
`timescale 1ns/1ps
`include "seep_defs.svh"
module seep_engine
    import seep_pkg::*;
#(
    parameter int AW         = 15,               // 14 or 15 decoded bits
    parameter int TWC_CYCLES = `SEEP_TWC_CYCLES  // Self-timed cycle length
) (
    input  wire logic CLK,
    input  wire logic NRST,
    input  wire logic SCK,             // Serial clock, mode 0/3
    input  wire logic CS_N,            // Chip select, active low
    input  wire logic SI,              // Serial data in
    input  wire logic WP_N,            // Protect pin, active low
    input  wire logic GATE_SET,        // Load new gate/level bits (stand-in)
    input  wire logic GATE_IN,         // Requested protect_pin_gate value
    input  wire logic [1:0] LEVEL_IN,  // Requested block level
    output logic      SO,              // Serial data out
    output logic      SO_OE,           // Output enable for SO
    output logic      BUSY,            // Programming cycle running
    output logic      WRITE_LATCH,     // Write-enable latch
    output logic      PROTECT_PIN_GATE,
    output logic      BLOCK_LEVEL_LO,
    output logic      BLOCK_LEVEL_HI
);
    // ======================================================================
    // Elaboration check
    initial begin
        if (AW != 14 && AW != 15) $error("seep_engine: AW must be 14 or 15");
        if (TWC_CYCLES < 1) $error("seep_engine: TWC_CYCLES must be positive");
    end

    // ======================================================================
    // Edge detection of serial pins
    logic sck_d_reg, sck_d_next;  // Last SCK
    logic cs_d_reg,  cs_d_next;   // Last CS_N
    logic sck_rise, sck_fall, cs_fall, cs_rise;

    always_comb begin
        sck_d_next = SCK;
        cs_d_next  = CS_N;
    end
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            sck_d_reg <= 1'b0;
            cs_d_reg  <= 1'b1;
        end else begin
            sck_d_reg <= sck_d_next;
            cs_d_reg  <= cs_d_next;
        end
    end
    assign sck_rise = SCK & ~sck_d_reg & ~CS_N;
    assign sck_fall = ~SCK & sck_d_reg & ~CS_N;
    assign cs_fall  = ~CS_N & cs_d_reg;
    assign cs_rise  = CS_N & ~cs_d_reg;

    // ======================================================================
    // Protection decode
    // Level to lowest protected address; array split into quarters
    function automatic logic prot_hit(input logic [1:0] lvl, input logic [AW-1:0] a);
        logic [1:0] q;
        q = a[AW-1:AW-2];
        unique case (lvl)
            2'b00: prot_hit = 1'b0;
            2'b01: prot_hit = (q == 2'b11);
            2'b10: prot_hit = q[1];
            2'b11: prot_hit = 1'b1;
        endcase
    endfunction : prot_hit

    // ======================================================================
    // Protocol state
    seep_phase_t     phase_reg, phase_next;    // Frame phase
    logic [3:0]      bit_reg,   bit_next;      // Bit counter in byte/word
    logic [15:0]     shin_reg,  shin_next;     // Input shifter
    logic [7:0]      shout_reg, shout_next;    // Output shifter
    logic [AW-1:0]   addr_reg,  addr_next;     // Working address
    logic            op_wr_reg, op_wr_next;    // Frame is a write
    logic            ld_reg,    ld_next;       // Load new array byte
    logic            so_reg,    so_next;
    logic            oe_reg,    oe_next;
    // Page buffer: write requests are staged and committed at CS rise
    logic [7:0]      pg_data_reg [0:63];
    logic [63:0]     pg_vld_reg, pg_vld_next;
    logic [AW-7:0]   pg_base_reg, pg_base_next; // Upper address bits of page
    logic            pg_wr_reg, pg_wr_next;     // Buffered byte write this cycle
    logic [5:0]      pg_wi;
    logic            commit_reg, commit_next;   // Flush in progress
    logic [5:0]      cidx_reg,  cidx_next;
    // Status/protect state
    logic            latch_reg, latch_next;
    logic            gate_reg,  gate_next;
    logic [1:0]      lvl_reg,   lvl_next;
    logic            busy_reg,  busy_next;
    logic [$clog2(TWC_CYCLES+1)-1:0] twc_reg, twc_next; // Busy countdown
    logic            hw_prot;
    logic [7:0]      status;
    logic [7:0]      rdata;
    seep_wr_t        mwr;
    logic [AW-1:0]   raddr;
    logic [2:0]      op3;

    assign hw_prot = gate_reg & ~WP_N;
    // The page flush already counts as the programming cycle for a poller
    assign status  = (busy_reg || commit_reg) ? 8'hFF :
                     {gate_reg, 3'h0, lvl_reg, latch_reg, 1'b0};
    assign op3     = shin_reg[2:0];
    assign pg_wi   = addr_reg[5:0];

    // ======================================================================
    // Serial protocol next-state
    always_comb begin
        phase_next = phase_reg;
        bit_next   = bit_reg;
        shin_next  = shin_reg;
        shout_next = shout_reg;
        addr_next  = addr_reg;
        op_wr_next = op_wr_reg;
        ld_next    = 1'b0;
        so_next    = so_reg;
        oe_next    = oe_reg;
        pg_vld_next  = pg_vld_reg;
        pg_base_next = pg_base_reg;
        pg_wr_next   = 1'b0;
        latch_next   = latch_reg;
        if (cs_fall) begin
            // New frame: all decode state restarts
            phase_next = SEEP_OPC;
            bit_next   = 4'h0;
            op_wr_next = 1'b0;
            // A status poll may open during the flush; keep its page flags
            if (!commit_reg) begin
                pg_vld_next = 64'h0;
            end
        end else if (CS_N) begin
            oe_next = 1'b0;  // Released outside frames
        end else if (sck_rise) begin
            shin_next = {shin_reg[14:0], SI};
            bit_next  = bit_reg + 4'h1;
            unique case (phase_reg)
                SEEP_OPC: begin
                    if (bit_reg == 4'h7) begin
                        bit_next = 4'h0;
                        if (shin_reg[6:3] != 4'h0) begin
                            phase_next = SEEP_IGN;     // Invalid opcode
                        end else if (busy_reg || commit_reg) begin
                            // Only status reads run during programming
                            phase_next = ({shin_reg[1:0], SI} == `SEEP_OP_READ_STATUS)
                                         ? SEEP_STAT : SEEP_IGN;
                        end else begin
                            unique case ({shin_reg[1:0], SI})
                                `SEEP_OP_SET_WRITE_LATCH: begin
                                    latch_next = 1'b1;
                                    phase_next = SEEP_IGN;
                                end
                                `SEEP_OP_CLR_WRITE_LATCH: begin
                                    latch_next = 1'b0;
                                    phase_next = SEEP_IGN;
                                end
                                `SEEP_OP_READ_STATUS: phase_next = SEEP_STAT;
                                `SEEP_OP_READ_ARRAY:  phase_next = SEEP_ADR;
                                `SEEP_OP_WRITE_ARRAY: begin
                                    // Write without latch is dropped till next frame
                                    phase_next = latch_reg ? SEEP_ADR : SEEP_IGN;
                                    op_wr_next = 1'b1;
                                end
                                default: phase_next = SEEP_IGN;
                            endcase
                        end
                    end
                end
                SEEP_ADR: begin
                    if (bit_reg == 4'hF) begin
                        bit_next  = 4'h0;
                        addr_next = {shin_reg[AW-2:0], SI};
                        if (op_wr_reg) begin
                            phase_next   = SEEP_WDAT;
                            pg_base_next = shin_reg[AW-2:5];
                        end else begin
                            phase_next = SEEP_RDAT;
                            ld_next    = 1'b1;
                        end
                    end
                end
                SEEP_WDAT: begin
                    if (bit_reg == 4'h7) begin
                        bit_next = 4'h0;
                        pg_wr_next = 1'b1;
                        pg_vld_next[pg_wi] = 1'b1;
                        // Only the low six bits advance, page wraps
                        addr_next = {addr_reg[AW-1:6], addr_reg[5:0] + 6'h01};
                    end
                end
                default: begin
                    // Read phases: input is don't-care
                    shin_next = shin_reg;
                    bit_next  = (bit_reg == 4'h7) ? 4'h0 : bit_reg + 4'h1;
                end
            endcase
        end else if (sck_fall) begin
            if (phase_reg == SEEP_RDAT || phase_reg == SEEP_STAT) begin
                oe_next = 1'b1;
                if (bit_reg == 4'h0) begin
                    // New byte: present MSB first
                    so_next    = (phase_reg == SEEP_STAT) ? status[7] : rdata[7];
                    shout_next = ((phase_reg == SEEP_STAT) ? status : rdata) << 1;
                    if (phase_reg == SEEP_RDAT) begin
                        addr_next = addr_reg + 1'b1;
                        ld_next   = 1'b1;
                    end
                end else begin
                    so_next    = shout_reg[7];
                    shout_next = shout_reg << 1;
                end
            end
        end
        if (ld_reg) begin
            // Nothing; registered read completes one CLK later
            ld_next = 1'b0;
        end
        if (busy_reg && twc_reg == 1) begin
            latch_next = 1'b0;
        end
    end

    // Page data store written in place
    always_ff @(posedge CLK) begin
        if (pg_wr_next) begin
            pg_data_reg[pg_wi] <= shin_next[7:0];
        end
    end

    // ======================================================================
    // Commit and programming timer
    always_comb begin
        commit_next = commit_reg;
        cidx_next   = cidx_reg;
        busy_next   = busy_reg;
        twc_next    = twc_reg;
        mwr         = '0;
        gate_next   = gate_reg;
        lvl_next    = lvl_reg;
        if (cs_rise && phase_reg == SEEP_WDAT && op_wr_reg && pg_vld_reg != 64'h0) begin
            commit_next = 1'b1;
            cidx_next   = 6'h00;
        end else if (commit_reg) begin
            mwr.addr = 15'({pg_base_reg, cidx_reg});
            mwr.data = pg_data_reg[cidx_reg];
            mwr.we   = pg_vld_reg[cidx_reg]
                       & ~prot_hit(lvl_reg, {pg_base_reg, cidx_reg});
            cidx_next = cidx_reg + 6'h01;
            if (cidx_reg == 6'h3F) begin
                commit_next = 1'b0;
                busy_next   = 1'b1;
                twc_next    = ($clog2(TWC_CYCLES+1))'(TWC_CYCLES);
            end
        end else if (busy_reg) begin
            twc_next = twc_reg - 1'b1;
            if (twc_reg == 1) begin
                busy_next = 1'b0;
            end
        end
        if (GATE_SET && latch_reg && !hw_prot && !busy_reg && !commit_reg) begin
            lvl_next  = LEVEL_IN;
            gate_next = GATE_IN;
        end else if (GATE_SET && hw_prot && GATE_IN) begin
            gate_next = 1'b1;  // clearing refused, setting harmless
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            phase_reg <= SEEP_IGN;  bit_reg <= 4'h0;   shin_reg <= 16'h0000;
            shout_reg <= 8'h00;     addr_reg <= '0;    op_wr_reg <= 1'b0;
            ld_reg <= 1'b0;         so_reg <= 1'b0;    oe_reg <= 1'b0;
            pg_vld_reg <= 64'h0;    pg_base_reg <= '0; pg_wr_reg <= 1'b0;
            commit_reg <= 1'b0;     cidx_reg <= 6'h00; latch_reg <= 1'b0;
            gate_reg <= `SEEP_GATE_RESET;  lvl_reg <= `SEEP_LEVEL_RESET;
            busy_reg <= 1'b0;       twc_reg <= '0;
        end else begin
            phase_reg <= phase_next; bit_reg <= bit_next; shin_reg <= shin_next;
            shout_reg <= shout_next; addr_reg <= addr_next; op_wr_reg <= op_wr_next;
            ld_reg <= ld_next;       so_reg <= so_next;   oe_reg <= oe_next;
            pg_vld_reg <= pg_vld_next; pg_base_reg <= pg_base_next;
            pg_wr_reg <= pg_wr_next; commit_reg <= commit_next; cidx_reg <= cidx_next;
            latch_reg <= latch_next; gate_reg <= gate_next; lvl_reg <= lvl_next;
            busy_reg <= busy_next;   twc_reg <= twc_next;
        end
    end

    // ======================================================================
    // Array memory; read address is the working address
    assign raddr = addr_reg;
    seep_mem #(.AW(AW)) u_mem (
        .clk   (CLK),
        .wr    (mwr),
        .raddr (raddr),
        .rdata (rdata)
    );

    // Outputs straight from flip-flops
    assign SO               = so_reg;
    assign SO_OE            = oe_reg;
    assign BUSY             = busy_reg;
    assign WRITE_LATCH      = latch_reg;
    assign PROTECT_PIN_GATE = gate_reg;
    assign BLOCK_LEVEL_LO   = lvl_reg[0];
    assign BLOCK_LEVEL_HI   = lvl_reg[1];

    // ======================================================================
    // Checks
    property p_gate_hold;
        @(posedge CLK) disable iff (!NRST) (gate_reg && !WP_N) |=> gate_reg;
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("gate cleared under protect");

    property p_busy_status;
        @(posedge CLK) disable iff (!NRST) (busy_reg || commit_reg) |-> status[0];
    endproperty
    a_busy_status: assert property (p_busy_status) else $error("busy not in status");

    property p_latch_end;
        @(posedge CLK) disable iff (!NRST) $fell(busy_reg) |-> !latch_reg;
    endproperty
    a_latch_end: assert property (p_latch_end) else $error("latch kept after cycle");

    property p_no_prot_wr;
        @(posedge CLK) disable iff (!NRST) mwr.we |-> !prot_hit(lvl_reg, mwr.addr[AW-1:0]);
    endproperty
    a_no_prot_wr: assert property (p_no_prot_wr) else $error("protected write");

    property p_commit_csh;
        @(posedge CLK) disable iff (!NRST) $rose(commit_reg) |-> cs_d_reg && !$past(cs_d_reg);
    endproperty
    a_commit_csh: assert property (p_commit_csh) else $error("commit before deselect");

    property p_busy_ignore;
        @(posedge CLK) disable iff (!NRST) busy_reg |=> $stable(lvl_reg);
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("level changed while busy");

    property p_no_latch_wr;
        @(posedge CLK) disable iff (!NRST)
            (phase_reg == SEEP_OPC && phase_next == SEEP_ADR && op_wr_next) |-> latch_reg;
    endproperty
    a_no_latch_wr: assert property (p_no_latch_wr) else $error("write taken without latch");

    property p_page_inc;
        @(posedge CLK) disable iff (!NRST)
            pg_wr_reg |-> addr_reg[AW-1:6] == $past(addr_reg[AW-1:6]);
    endproperty
    a_page_inc: assert property (p_page_inc) else $error("page bits moved");
endmodule : seep_engine

// *** testbench/seep_master_model.sv ***
// SPI mode 0 master standing in for the host controller of the EEPROM engine.
// Assumes a free-running CLK; SO is pulled up whenever the engine releases it.
`timescale 1ns/1ps
module seep_master_model #(
    parameter int HALF = 3  // SCK half period in CLK cycles, keeps SCK under CLK/4
) (
    input  wire logic CLK,
    output logic      SCK,
    output logic      CS_N,
    output logic      SI,
    input  wire logic SO,
    input  wire logic SO_OE
);
    logic       so_line;  // Level the master sees on the shared SO wire
    logic [7:0] rx;       // Last byte captured from SO
    event       got;      // Fires for bytes the bench wants compared

    // Released SO floats to the pull-up level
    assign so_line = SO_OE ? SO : 1'b1;

    // Idle lines: clock rests low, select high
    initial begin
        SCK  = 1'b0;
        CS_N = 1'b1;
        SI   = 1'b0;
    end

    // ======================================================================
    // Step n CLK edges, then move just after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask : tick

    // Every frame opens with select falling
    task automatic open_frame();
        tick(HALF);
        CS_N = 1'b0;
        tick(HALF);
    endtask : open_frame

    // One byte each way, MSB first; SO sampled at SCK rise, where it is settled
    task automatic xbyte(input logic [7:0] tx, input bit chk);
        for (int i = 7; i >= 0; i--) begin
            SI = tx[i];
            tick(HALF);
            SCK   = 1'b1;
            rx[i] = so_line;
            tick(HALF);
            SCK = 1'b0;
        end
        if (chk) ->got;
    endtask : xbyte

    // Select rises inside the low phase that follows bit 0
    task automatic close_frame();
        tick(1);
        CS_N = 1'b1;
        SI   = ~SI;   // Released data line must not look stable
        tick(2 * HALF);
    endtask : close_frame
endmodule : seep_master_model

// *** testbench/seep_engine_tb.sv ***
// Self-checking bench for the serial EEPROM command engine.
// Assumes the master model drives the serial side; a shadow array predicts read data.
`timescale 1ns/1ps
module seep_engine_tb;
    import seep_pkg::*;
    localparam int TWC = 300;  // Short self-timed cycle, still longer than a status frame
    logic CLK, NRST, SCK, CS_N, SI, WP_N, GATE_SET, GATE_IN, SO, SO_OE, BUSY;
    logic WRITE_LATCH, PROTECT_PIN_GATE, BLOCK_LEVEL_LO, BLOCK_LEVEL_HI;
    logic [1:0]  LEVEL_IN;
    logic [15:0] notes [$];            // Expected bytes: {mask, value}
    logic [7:0]  shadow [logic [14:0]];  // Predicted array contents
    logic [1:0]  lvl;                  // Block level currently set
    int          err_total, n_compared, seed_word;
    logic [15:0] addrs [3] = '{16'h0000, 16'h4000, 16'h6000};  // One per protect segment

    seep_master_model i_seep_master_model (.CLK(CLK), .SCK(SCK), .CS_N(CS_N), .SI(SI),
        .SO(SO), .SO_OE(SO_OE));
    seep_engine #(.AW(15), .TWC_CYCLES(TWC)) i_seep_engine (.CLK(CLK), .NRST(NRST),
        .SCK(SCK), .CS_N(CS_N), .SI(SI), .WP_N(WP_N), .GATE_SET(GATE_SET),
        .GATE_IN(GATE_IN), .LEVEL_IN(LEVEL_IN), .SO(SO), .SO_OE(SO_OE), .BUSY(BUSY),
        .WRITE_LATCH(WRITE_LATCH), .PROTECT_PIN_GATE(PROTECT_PIN_GATE),
        .BLOCK_LEVEL_LO(BLOCK_LEVEL_LO), .BLOCK_LEVEL_HI(BLOCK_LEVEL_HI));

    // ======================================================================
    // Clock and watchdog
    initial begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end
    initial begin
        repeat (60000) @(posedge CLK);
        err_total++;
        close_out();
    end

    // ======================================================================
    // Shared helpers
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask : tick
    // Array addresses in the protected range of the current level
    function automatic bit prot(input logic [14:0] a);
        return (lvl == 2'h3) || (lvl == 2'h2 && a >= 15'h4000) ||
               (lvl == 2'h1 && a >= 15'h6000);
    endfunction : prot
    // Wait for BUSY to reach level v, bounded
    task automatic wait_busy(input logic v, input int lim);
        for (int c = 0; c < lim && BUSY !== v; c++) tick(1);
    endtask : wait_busy
    // Write-enable frame; bit 3 of the opcode is a random don't-care
    task automatic latch_on();
        i_seep_master_model.open_frame();
        i_seep_master_model.xbyte({4'h0, 1'($urandom), 3'h6}, 0);
        i_seep_master_model.close_frame();
        chk("write_latch", 8'h01, {7'h0, WRITE_LATCH});
    endtask : latch_on
    // Status write stand-in through the gate ports
    task automatic gate(input logic g, input logic [1:0] l);
        latch_on();
        GATE_IN  = g;
        LEVEL_IN = l;
        GATE_SET = 1'b1;
        tick(1);
        GATE_SET = 1'b0;
        tick(4);
    endtask : gate
    // Write n random bytes at a; mode 0 no commit, 1 commit, 2 either
    task automatic wr(input logic [15:0] a, input int n, input int mode);
        logic [7:0]  d;
        logic [15:0] p;
        i_seep_master_model.open_frame();
        i_seep_master_model.xbyte(8'h02, 0);
        i_seep_master_model.xbyte(a[15:8], 0);
        i_seep_master_model.xbyte(a[7:0], 0);
        for (int k = 0; k < n; k++) begin
            d = 8'($urandom);
            p = {a[15:6], a[5:0] + 6'(k)};
            if (mode != 0 && !prot(p[14:0])) shadow[p[14:0]] = d;
            i_seep_master_model.xbyte(d, 0);
        end
        chk("busy_before_rise", 8'h00, {7'h0, BUSY});
        i_seep_master_model.close_frame();
        wait_busy(1'b1, (mode == 0) ? 120 : 300);
        if (mode == 1) begin
            chk("busy_started", 8'h01, {7'h0, BUSY});
            notes.push_back(16'h0101);
            i_seep_master_model.open_frame();
            i_seep_master_model.xbyte(8'h05, 0);
            i_seep_master_model.xbyte(8'($urandom), 1);
            i_seep_master_model.close_frame();
            // Latch clear must be ignored while the cycle runs
            i_seep_master_model.open_frame();
            i_seep_master_model.xbyte(8'h04, 0);
            i_seep_master_model.close_frame();
            chk("latch_kept_busy", 8'h01, {7'h0, WRITE_LATCH});
        end
        if (mode == 0) chk("busy_refused", 8'h00, {7'h0, BUSY});
        wait_busy(1'b0, 400);
        if (mode == 1) begin
            chk("latch_cleared", 8'h00, {7'h0, WRITE_LATCH});
            // Poll once more: ready and write-disabled
            notes.push_back(16'h0300);
            i_seep_master_model.open_frame();
            i_seep_master_model.xbyte(8'h05, 0);
            i_seep_master_model.xbyte(8'($urandom), 1);
            i_seep_master_model.close_frame();
        end
    endtask : wr
    // Read n bytes from a; SI carries noise after the address
    task automatic rd(input logic [15:0] a, input int n);
        i_seep_master_model.open_frame();
        i_seep_master_model.xbyte(8'h03, 0);
        i_seep_master_model.xbyte(a[15:8], 0);
        i_seep_master_model.xbyte(a[7:0], 0);
        for (int k = 0; k < n; k++) begin
            notes.push_back({8'hFF, shadow[15'(a + 16'(k))]});
            i_seep_master_model.xbyte(8'($urandom), 1);
        end
        i_seep_master_model.close_frame();
    endtask : rd

    // ======================================================================
    // Monitor: oldest note against each byte the bench wants compared
    always @(i_seep_master_model.got) begin
        logic [15:0] nt;
        nt = notes.pop_front();
        chk("so_byte", nt[7:0] & nt[15:8], i_seep_master_model.rx & nt[15:8]);
    end

    // ======================================================================
    // Main sequence
    initial begin
        NRST      = 1'b0;
        WP_N      = 1'b1;
        GATE_SET  = 1'b0;
        GATE_IN   = 1'b0;
        LEVEL_IN  = 2'h0;
        lvl       = 2'h0;
        seed_word = $urandom(32'h47063c5e);
        tick(8);
        NRST = 1'b0 | 1'b1;
        tick(2);
        chk("reset_state", 8'h00, {6'h0, WRITE_LATCH, BUSY});
        // Every level against one address per segment, top bit of address ignored
        for (int l = 0; l < 4; l++) begin
            lvl = 2'(l);
            gate(1'b0, lvl);
            chk("block_level", {6'h0, lvl}, {6'h0, BLOCK_LEVEL_HI, BLOCK_LEVEL_LO});
            foreach (addrs[i]) begin
                latch_on();
                wr(addrs[i], 1, 2);
                rd(addrs[i] | 16'h8000, 1);
            end
        end
        $display("test block protect done");
        lvl = 2'h0;
        gate(1'b0, 2'h0);
        latch_on();
        wr(16'h7FFE, 66, 1);
        rd(16'h7FC0, 65);
        $display("test page write done");
        latch_on();
        i_seep_master_model.open_frame();
        i_seep_master_model.xbyte(8'h04, 0);
        i_seep_master_model.close_frame();
        chk("latch_clear_cmd", 8'h00, {7'h0, WRITE_LATCH});
        wr(16'h0000, 1, 0);
        rd(16'h0000, 1);
        $display("test write without latch done");
        gate(1'b1, 2'h0);
        WP_N = 1'b0;
        gate(1'b0, 2'h0);
        chk("gate_held", 8'h01, {7'h0, PROTECT_PIN_GATE});
        WP_N = 1'b1;
        gate(1'b0, 2'h0);
        chk("gate_cleared", 8'h00, {7'h0, PROTECT_PIN_GATE});
        $display("test hardware protect done");
        close_out();
    end

    // Verdict and end of run
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
endmodule : seep_engine_tb
